// ### verilog/fesp_defs.svh
// Constants of the flash card host sequencer: timing, command codes, bit positions, map.
// Assumes a 25 MHz clock and a card bus sampled through two flip-flops.
`ifndef FESP_DEFS_SVH
`define FESP_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FESP_CLK_NS     40
`define FESP_T_ACC_NS   150
`define FESP_RD_CYC     ((`FESP_T_ACC_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_SYNC_LAT   2
`define FESP_RD_END     (`FESP_RD_CYC + `FESP_SYNC_LAT + 1)
`define FESP_WR_SETUP   1
`define FESP_WR_PULSE   2
`define FESP_WR_END     (`FESP_WR_SETUP + `FESP_WR_PULSE + 1)

// ----------------------------------------------------------------------------
// Device command codes (low byte; doubled in word mode)
// ----------------------------------------------------------------------------
`define FESP_CMD_SETUP    8'h20
`define FESP_CMD_CONFIRM  8'hD0
`define FESP_CMD_SUSPEND  8'hB0
`define FESP_CMD_RESUME   8'hD0
`define FESP_CMD_RDARRAY  8'hFF
`define FESP_CMD_RDSTAT   8'h70

// ----------------------------------------------------------------------------
// Device status bits (upper byte adds the offset)
// ----------------------------------------------------------------------------
`define FESP_SB_READY   7
`define FESP_SB_SUSP    6
`define FESP_SB_ERASE   5
`define FESP_SB_WRITE   4
`define FESP_SB_VPP     3
`define FESP_SB_UPPER   8
`define FESP_BLK_LSB    16

// ----------------------------------------------------------------------------
// Controller register indices and fields
// ----------------------------------------------------------------------------
`define FESP_R_CTRL     4'h0
`define FESP_R_ADDR     4'h1
`define FESP_R_CMD      4'h2
`define FESP_R_STATUS   4'h3
`define FESP_R_RDATA    4'h4
`define FESP_R_DEVSTAT  4'h5
`define FESP_R_IRQSTAT  4'h6
`define FESP_R_IRQMASK  4'h7
`define FESP_C_WORD     0
`define FESP_C_AUTORA   1
`define FESP_C_USEPIN   2
`define FESP_C_SLEEP    3
`define FESP_I_DONE     0
`define FESP_I_ERR      1
`define FESP_I_REFUSED  2

`endif

// ### verilog/fesp_pkg.sv
// Types of the flash card host sequencer.
// Assumes nothing beyond the constants header.
package fesp_pkg;
  typedef enum logic [3:0] {
    OP_ERASE, OP_WAIT, OP_SUSPEND, OP_RESUME, OP_READARR,
    OP_RDSTAT, OP_CLEAR, OP_READ, OP_SLEEP
  } fesp_op_e;
  typedef enum {ST_IDLE, ST_STEP, ST_BUSW, ST_BUSR, ST_PIN, ST_WAKE} fesp_state_e;
  typedef enum {ACT_WR, ACT_RD, ACT_POLL, ACT_PIN, ACT_WAKE, ACT_END} fesp_act_e;
endpackage

// ### verilog/fesp_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs arrive asynchronously from card pins.
module fesp_sync #(
  parameter int W = 17
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  // ----------------------------------------------------------------------------
  // Chains
  // ----------------------------------------------------------------------------
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    // First flop feeds only the second
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_q[i]  <= 1'b0;
        syncOut[i] <= 1'b0;
      end else begin
        meta_q[i]  <= asyncIn[i];
        syncOut[i] <= meta_q[i];
      end
    end
  end
endmodule

// ### verilog/fesp_host.sv
// Host-side sequencer that drives a flash memory card over its parallel pins.
// Assumes software on a plain register port and a card whose pins are asynchronous.
//
// Notes on behaviour
// - Suspend/resume codes single or doubled per width
// - Word mode ready needs bits 7 and 15
// - Read-array command after the final erase
// - Low supply failure blocks erase until clear
// - Completion by status polling or ready pin
// - Standby keeps both card enables high
// - Wait recovery after waking devices
// - Write needs write and card enable low
// - Erase needs setup then confirm command
//
// Decided for this implementation: the strobed register port and the address map.
`include "fesp_defs.svh"
module fesp_host import fesp_pkg::*; #(
  parameter int                ADDR_W     = 26,
  parameter logic [7:0]        CLEAR_CMD  = 8'h50,
  parameter logic [ADDR_W-1:0] SLEEP_ADDR = '0,
  parameter int                WAKE_CYC   = 64
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdata,
  output logic                   irq,
  output logic                   cardEnableLowN,
  output logic                   cardEnableHighN,
  output logic                   outEnableN,
  output logic                   writeEnableN,
  output logic      [ADDR_W-1:0] cardAddr,
  output logic      [15:0]       dqOut,
  output logic                   dqDriveN,
  input  wire logic [15:0]       dqIn,
  input  wire logic              readyBusyPin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Command word for the current width
  function automatic logic [15:0] cmdWord(input logic [7:0] code, input logic word);
    cmdWord = word ? {code, code} : {8'h00, code};
  endfunction

  // A status bit set in every active byte
  function automatic logic bothSet(input logic [15:0] s, input int b, input logic word);
    bothSet = s[b] && (!word || s[b + `FESP_SB_UPPER]);
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  fesp_state_e       stateQ;
  fesp_op_e          opQ;
  fesp_act_e         act;
  logic [2:0]        stepQ;
  logic [15:0]       cntQ;
  logic [ADDR_W-1:0] busAddrQ;
  logic [ADDR_W-1:0] reqAddrQ;
  logic [ADDR_W-1:0] suspAddrQ;
  logic [15:0]       busDataQ;
  logic [15:0]       readDataQ;
  logic [15:0]       devStatQ;
  logic [3:0]        ctrlQ;
  logic [2:0]        irqStatQ;
  logic [2:0]        irqStatD;
  logic [2:0]        irqMaskQ;
  logic              eraseActiveQ;
  logic              suspendedQ;
  logic              vppLockQ;
  logic              failQ;
  logic [7:0]        actCode;
  logic              actSleep;
  logic [16:0]       syncBus;
  logic [15:0]       dqSync;
  logic              rdySync;
  logic              wordMode;
  logic              cmdStart;
  logic              refuse;
  logic              finish;
  logic              statErr;
  logic              sameBlock;
  logic              rdEnd;
  logic              wrEnd;

  assign wordMode  = ctrlQ[`FESP_C_WORD];
  assign cmdStart  = regWr && (regAddr == `FESP_R_CMD);
  assign finish    = (stateQ == ST_STEP) && (act == ACT_END);
  assign rdEnd     = (stateQ == ST_BUSR) && (cntQ == 16'(`FESP_RD_END));
  assign wrEnd     = (stateQ == ST_BUSW) && (cntQ == 16'(`FESP_WR_END));
  assign dqSync    = syncBus[15:0];
  assign rdySync   = syncBus[16];
  assign sameBlock = (reqAddrQ[ADDR_W-1:`FESP_BLK_LSB] == suspAddrQ[ADDR_W-1:`FESP_BLK_LSB]);

  // Card data and ready pin cross into the clock domain
  fesp_sync #(.W(17)) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({readyBusyPin, dqIn}),
    .syncOut (syncBus)
  );

  // ----------------------------------------------------------------------------
  // Command acceptance
  // ----------------------------------------------------------------------------
  // Refuse commands the card would not take in its present condition
  always_comb begin
    refuse = (stateQ != ST_IDLE) || (regWdata[3:0] > 4'(OP_SLEEP));
    unique case (regWdata[3:0])
      4'(OP_ERASE):   refuse = refuse || vppLockQ || suspendedQ || eraseActiveQ;
      4'(OP_SUSPEND): refuse = refuse || !eraseActiveQ || suspendedQ;
      4'(OP_RESUME):  refuse = refuse || !suspendedQ;
      4'(OP_READ):    refuse = refuse || (suspendedQ && sameBlock);
      4'(OP_READARR), 4'(OP_RDSTAT): refuse = refuse;
      default:        refuse = refuse || suspendedQ;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Step table: what each operation does at each step
  // ----------------------------------------------------------------------------
  always_comb begin
    act      = ACT_END;
    actCode  = `FESP_CMD_RDARRAY;
    actSleep = 1'b0;
    unique case (opQ)
      OP_ERASE: begin
        // Two-step sequence: setup then confirm
        if (stepQ == 3'd0) begin act = ACT_WR; actCode = `FESP_CMD_SETUP; end
        else if (stepQ == 3'd1) begin act = ACT_WR; actCode = `FESP_CMD_CONFIRM; end
      end
      OP_WAIT: begin
        if (stepQ == 3'd0) begin act = ACT_WR; actCode = `FESP_CMD_RDSTAT; end
        else if (stepQ == 3'd1) act = ctrlQ[`FESP_C_USEPIN] ? ACT_PIN : ACT_POLL;
        else if (stepQ == 3'd2) act = ACT_RD;
        else if (stepQ == 3'd3 && ctrlQ[`FESP_C_AUTORA]) act = ACT_WR;
      end
      OP_SUSPEND: begin
        if (stepQ == 3'd0) begin act = ACT_WR; actCode = `FESP_CMD_SUSPEND; end
        else if (stepQ == 3'd1) act = ACT_POLL;
      end
      OP_RESUME: begin
        if (stepQ == 3'd0) begin act = ACT_WR; actCode = `FESP_CMD_RESUME; end
        else if (stepQ == 3'd1) act = ACT_POLL;
      end
      OP_READARR: if (stepQ == 3'd0) act = ACT_WR;
      OP_RDSTAT: begin
        if (stepQ == 3'd0) begin act = ACT_WR; actCode = `FESP_CMD_RDSTAT; end
        else if (stepQ == 3'd1) act = ACT_RD;
      end
      OP_CLEAR: if (stepQ == 3'd0) begin act = ACT_WR; actCode = CLEAR_CMD; end
      OP_READ: if (stepQ == 3'd0) act = ACT_RD;
      OP_SLEEP: begin
        if (stepQ == 3'd0) begin act = ACT_WR; actSleep = 1'b1; end
        else if (stepQ == 3'd1 && !ctrlQ[`FESP_C_SLEEP]) act = ACT_WAKE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  // Walks the steps of the current operation and times each bus cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateQ   <= ST_IDLE;
      opQ      <= OP_READARR;
      stepQ    <= 3'd0;
      cntQ     <= 16'h0000;
      busAddrQ <= '0;
      busDataQ <= 16'h0000;
    end else begin
      cntQ <= cntQ + 16'h0001;
      unique case (stateQ)
        ST_IDLE: begin
          if (cmdStart && !refuse) begin
            opQ    <= fesp_op_e'(regWdata[3:0]);
            stepQ  <= 3'd0;
            stateQ <= ST_STEP;
          end
        end
        ST_STEP: begin
          cntQ     <= 16'h0000;
          busAddrQ <= actSleep ? SLEEP_ADDR : reqAddrQ;
          busDataQ <= actSleep ? {15'h0000, ctrlQ[`FESP_C_SLEEP]} : cmdWord(actCode, wordMode);
          unique case (act)
            ACT_WR:           stateQ <= ST_BUSW;
            ACT_RD, ACT_POLL: stateQ <= ST_BUSR;
            ACT_PIN:          stateQ <= ST_PIN;
            ACT_WAKE:         stateQ <= ST_WAKE;
            ACT_END:          stateQ <= ST_IDLE;
          endcase
        end
        ST_BUSW: begin
          if (wrEnd) begin
            stepQ  <= stepQ + 3'd1;
            stateQ <= ST_STEP;
          end
        end
        ST_BUSR: begin
          // A poll read repeats until every active byte reports ready
          if (rdEnd) begin
            if (act != ACT_POLL || bothSet(dqSync, `FESP_SB_READY, wordMode))
              stepQ <= stepQ + 3'd1;
            stateQ <= ST_STEP;
          end
        end
        ST_PIN: begin
          if (rdySync) begin
            stepQ  <= stepQ + 3'd1;
            stateQ <= ST_STEP;
          end
        end
        ST_WAKE: begin
          if (cntQ == 16'(WAKE_CYC - 1)) stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Card pins
  // ----------------------------------------------------------------------------
  // Enables sit high whenever no bus cycle runs, inhibiting stray writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cardEnableLowN  <= 1'b1;
      cardEnableHighN <= 1'b1;
      outEnableN      <= 1'b1;
      writeEnableN    <= 1'b1;
      dqDriveN        <= 1'b1;
      cardAddr        <= '0;
      dqOut           <= 16'h0000;
    end else begin
      cardEnableLowN  <= !(stateQ == ST_BUSW || stateQ == ST_BUSR);
      cardEnableHighN <= !((stateQ == ST_BUSW || stateQ == ST_BUSR) && wordMode);
      outEnableN      <= !(stateQ == ST_BUSR);
      dqDriveN        <= !(stateQ == ST_BUSW);
      writeEnableN    <= !(stateQ == ST_BUSW && cntQ >= 16'(`FESP_WR_SETUP) &&
                           cntQ < 16'(`FESP_WR_SETUP + `FESP_WR_PULSE));
      cardAddr        <= busAddrQ;
      dqOut           <= busDataQ;
    end
  end

  AST_STANDBY_CE: assert property (stateQ == ST_IDLE |=> cardEnableLowN && cardEnableHighN)
    else $error("card enabled while idle");
  AST_WRITE_GATED: assert property (!writeEnableN |-> !cardEnableLowN && !dqDriveN)
    else $error("write strobe without card enable or data");
  AST_WRITE_PULSE: assert property ($fell(writeEnableN) |=> !writeEnableN ##1 writeEnableN)
    else $error("write strobe not two cycles");
  AST_ERASE_SEQ: assert property (stateQ == ST_BUSW && opQ == OP_ERASE |->
      busDataQ == cmdWord(stepQ == 3'd0 ? `FESP_CMD_SETUP : `FESP_CMD_CONFIRM, wordMode))
    else $error("erase sequence codes wrong");
  AST_SUSP_CODE: assert property (stateQ == ST_BUSW && opQ == OP_SUSPEND |->
      busDataQ == (wordMode ? 16'hB0B0 : 16'h00B0))
    else $error("suspend code wrong");
  AST_RESUME_CODE: assert property (stateQ == ST_BUSW && opQ == OP_RESUME |->
      busDataQ == (wordMode ? 16'hD0D0 : 16'h00D0))
    else $error("resume code wrong");
  AST_WAKE_WAIT: assert property ($rose(stateQ == ST_WAKE) |-> (stateQ == ST_WAKE) [*8])
    else $error("recovery wait cut short");
  AST_PIN_WAIT: assert property (stateQ == ST_PIN && !rdySync |=> stateQ == ST_PIN)
    else $error("left pin wait while busy");
  AST_AUTO_RA: assert property (stateQ == ST_STEP && opQ == OP_WAIT && stepQ == 3'd3 &&
      ctrlQ[`FESP_C_AUTORA] |=> stateQ == ST_BUSW &&
      busDataQ == cmdWord(`FESP_CMD_RDARRAY, wordMode))
    else $error("read array not issued after erase");

  // ----------------------------------------------------------------------------
  // Captured data and card condition
  // ----------------------------------------------------------------------------
  // Status words feed the error checks; array words go to software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readDataQ <= 16'h0000;
      devStatQ  <= 16'h0000;
    end else if (rdEnd) begin
      readDataQ <= dqSync;
      if (opQ != OP_READ) devStatQ <= dqSync;
    end
  end

  assign statErr = finish && (opQ == OP_WAIT || opQ == OP_RESUME || opQ == OP_RDSTAT) &&
                   (devStatQ[`FESP_SB_VPP] || devStatQ[`FESP_SB_ERASE] ||
                    devStatQ[`FESP_SB_VPP + `FESP_SB_UPPER] ||
                    devStatQ[`FESP_SB_ERASE + `FESP_SB_UPPER]);

  // Erase, suspension and lock flags; after reset the card is in array read mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eraseActiveQ <= 1'b0;
      suspendedQ   <= 1'b0;
      vppLockQ     <= 1'b0;
      failQ        <= 1'b0;
      suspAddrQ    <= '0;
    end else if (finish) begin
      unique case (opQ)
        OP_ERASE:   eraseActiveQ <= 1'b1;
        OP_WAIT:    eraseActiveQ <= 1'b0;
        OP_SUSPEND: begin
          suspendedQ <= bothSet(devStatQ, `FESP_SB_SUSP, wordMode);
          suspAddrQ  <= reqAddrQ;
          if (!bothSet(devStatQ, `FESP_SB_SUSP, wordMode)) eraseActiveQ <= 1'b0;
        end
        OP_RESUME:  suspendedQ <= 1'b0;
        OP_CLEAR: begin
          vppLockQ <= 1'b0;
          failQ    <= 1'b0;
        end
        default: begin
        end
      endcase
      // Supply failure locks out erase until status is cleared
      if (statErr && (devStatQ[`FESP_SB_VPP] || devStatQ[`FESP_SB_VPP + `FESP_SB_UPPER]))
        vppLockQ <= 1'b1;
      if (statErr) failQ <= 1'b1;
    end
  end

  AST_VPP_REFUSE: assert property (cmdStart && regWdata[3:0] == 4'(OP_ERASE) && vppLockQ &&
      stateQ == ST_IDLE |=>
      stateQ == ST_IDLE && irqStatQ[`FESP_I_REFUSED])
    else $error("erase accepted under supply lock");
  AST_RESUME_READY: assert property (finish && opQ == OP_RESUME |->
      bothSet(devStatQ, `FESP_SB_READY, wordMode))
    else $error("resume finished before ready");

  // ----------------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------------
  // Software writes of control, address and mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrlQ    <= 4'h0;
      reqAddrQ <= '0;
      irqMaskQ <= 3'h0;
    end else if (regWr) begin
      if (regAddr == `FESP_R_CTRL) ctrlQ <= regWdata[3:0];
      if (regAddr == `FESP_R_ADDR && stateQ == ST_IDLE) reqAddrQ <= regWdata[ADDR_W-1:0];
      if (regAddr == `FESP_R_IRQMASK) irqMaskQ <= regWdata[2:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) regRdata <= 32'h0000_0000;
    else if (!regRd) regRdata <= 32'h0000_0000;
    else begin
      unique case (regAddr)
        `FESP_R_CTRL:    regRdata <= {28'h000_0000, ctrlQ};
        `FESP_R_ADDR:    regRdata <= 32'(reqAddrQ);
        `FESP_R_STATUS:  regRdata <= {27'h000_0000, failQ, vppLockQ, suspendedQ,
                                      eraseActiveQ, stateQ != ST_IDLE};
        `FESP_R_RDATA:   regRdata <= {16'h0000, readDataQ};
        `FESP_R_DEVSTAT: regRdata <= {16'h0000, devStatQ};
        `FESP_R_IRQSTAT: regRdata <= {29'h0000_0000, irqStatQ};
        `FESP_R_IRQMASK: regRdata <= {29'h0000_0000, irqMaskQ};
        default:         regRdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------------
  // Sticky events, cleared by reading; a new event wins over the clear
  always_comb begin
    irqStatD = irqStatQ;
    if (regRd && regAddr == `FESP_R_IRQSTAT) irqStatD = 3'h0;
    if (finish) irqStatD[`FESP_I_DONE] = 1'b1;
    if (statErr) irqStatD[`FESP_I_ERR] = 1'b1;
    if (cmdStart && refuse) irqStatD[`FESP_I_REFUSED] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStatQ <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irqStatQ <= irqStatD;
      irq      <= |(irqStatD & irqMaskQ);
    end
  end
endmodule

// ### test/fesp_card_model.sv
// Behavioural flash card for the host sequencer bench: status, erase, suspend, sleep.
// Assumes the host drives the card pins from flops on the same clock.
module fesp_card_model #(
  parameter int ERASE_CYC = 200
) (
  input  wire logic        clk,
  input  wire logic        ceLoN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [25:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        vppLow,
  output logic      [15:0] dqIn,
  output logic             rbPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  st = 8'h80;
  logic [15:0] lastCmd = 16'h0000;
  logic        weP = 1'b1;
  logic        stMode = 1'b0;
  logic        setupQ = 1'b0;
  logic        suspQ = 1'b0;
  logic        sleepQ = 1'b0;
  int          busyCnt = 0;
  int          eraseCnt = 0;
  initial dqIn = 16'h0000;
  // Command decode on the write-enable rising edge, erase countdown, read data
  always @(posedge clk) begin
    if (weN && !weP && !ceLoN) begin
      lastCmd = dq;
      if (setupQ) begin
        setupQ = 1'b0;
        if (dq[7:0] != 8'hD0) st = st | 8'h30;
        else if (vppLow || st[3]) st = st | 8'h28;
        else begin
          busyCnt = ERASE_CYC;
          eraseCnt++;
          st[7] = 1'b0;
        end
      end else if (!suspQ || dq[7:0] inside {8'hFF, 8'h70, 8'hD0}) begin
        stMode = (dq[7:0] != 8'hFF);
        case (dq[7:0])
          8'h20: setupQ = 1'b1;
          8'hB0: if (busyCnt > 0) {suspQ, st} = {1'b1, 8'hC0};
          8'hD0: if (suspQ) {suspQ, st} = {1'b0, st & 8'h3F};
          8'h50: st = st & 8'hC7;
          8'h00, 8'h01: sleepQ = dq[0];
          default: ;
        endcase
      end
    end
    weP = weN;
    if (busyCnt > 0 && !suspQ) begin
      busyCnt--;
      if (busyCnt == 0) st[7] = 1'b1;
    end
    rbPin <= st[7];
    // A released or sleeping bus toggles instead of holding its last value
    if (!ceLoN && !oeN && !sleepQ) dqIn <= stMode ? {st, st} : addr[15:0];
    else dqIn <= ~dqIn;
  end
endmodule

// ### test/fesp_host_tb_top.sv
// Self-checking bench of the flash card host sequencer.
// Assumes the design files and the card model are compiled first.
module fesp_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        vppLow = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata, s;
  logic        irq, ceLoN, ceHiN, oeN, weN, dqDriveN, rbPin;
  logic [25:0] cardAddr;
  logic [15:0] dqOut, dqIn;
  int          failCount = 0;
  int          nCompared = 0;
  time         t0;
  fesp_host #(.WAKE_CYC(16)) fesp_host_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
    .cardEnableLowN(ceLoN), .cardEnableHighN(ceHiN), .outEnableN(oeN), .writeEnableN(weN),
    .cardAddr(cardAddr), .dqOut(dqOut), .dqDriveN(dqDriveN), .dqIn(dqIn),
    .readyBusyPin(rbPin));
  fesp_card_model fesp_card_model_i (.clk(clk), .ceLoN(ceLoN), .oeN(oeN), .weN(weN),
    .addr(cardAddr), .dq(dqOut), .vppLow(vppLow), .dqIn(dqIn), .rbPin(rbPin));
  always #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Issue one operation and poll the busy flag under a bound
  task automatic op(input logic [31:0] code);
    wr(4'h2, code);
    s = 32'h0000_0001;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) rd(4'h3, s);
    chk(s & 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic tReset();
    chk({ceLoN, ceHiN, oeN, weN, dqDriveN}, 32'h0000_001F);
    chk(fesp_card_model_i.stMode, 32'h0000_0000);
  endtask
  task automatic tErase();
    wr(4'h7, 32'h0000_0007);
    wr(4'h0, 32'h0000_0002);
    wr(4'h1, 32'h0003_0000);
    op(32'h0000_0000);
    rd(4'h3, s);
    chk(s, 32'h0000_0002);
    chk(fesp_card_model_i.eraseCnt, 32'h0000_0001);
    op(32'h0000_0001);
    rd(4'h5, s);
    chk(s & 32'h0000_0080, 32'h0000_0080);
    chk(fesp_card_model_i.stMode, 32'h0000_0000);
    chk(irq, 32'h0000_0001);
    rd(4'h6, s);
    chk(s, 32'h0000_0001);
    @(posedge clk);
    #1 chk(irq, 32'h0000_0000);
  endtask
  task automatic tSuspend();
    wr(4'h0, 32'h0000_0001);
    op(32'h0000_0000);
    op(32'h0000_0002);
    chk(fesp_card_model_i.lastCmd, 32'h0000_B0B0);
    rd(4'h3, s);
    chk(s & 32'h0000_0004, 32'h0000_0004);
    op(32'h0000_0007);
    rd(4'h6, s);
    chk(s & 32'h0000_0004, 32'h0000_0004);
    wr(4'h1, 32'h0001_0004);
    op(32'h0000_0004);
    op(32'h0000_0007);
    rd(4'h4, s);
    chk(s & 32'h0000_FFFF, 32'h0000_0004);
    op(32'h0000_0003);
    chk(fesp_card_model_i.lastCmd, 32'h0000_D0D0);
    op(32'h0000_0001);
    rd(4'h3, s);
    chk(s, 32'h0000_0000);
    rd(4'h5, s);
    chk(s & 32'h0000_8080, 32'h0000_8080);
  endtask
  task automatic tVpp();
    wr(4'h0, 32'h0000_0004);
    vppLow <= 1'b1;
    op(32'h0000_0000);
    op(32'h0000_0001);
    rd(4'h3, s);
    chk(s & 32'h0000_0018, 32'h0000_0018);
    rd(4'h6, s);
    op(32'h0000_0000);
    rd(4'h6, s);
    chk(s & 32'h0000_0004, 32'h0000_0004);
    vppLow <= 1'b0;
    op(32'h0000_0006);
    chk(fesp_card_model_i.st & 8'h38, 32'h0000_0000);
    op(32'h0000_0000);
    op(32'h0000_0001);
    rd(4'h3, s);
    chk(s, 32'h0000_0000);
  endtask
  task automatic tSleep();
    wr(4'h0, 32'h0000_0008);
    op(32'h0000_0008);
    chk(fesp_card_model_i.sleepQ, 32'h0000_0001);
    wr(4'h0, 32'h0000_0000);
    t0 = $time;
    op(32'h0000_0008);
    chk(fesp_card_model_i.sleepQ, 32'h0000_0000);
    chk(($time - t0) >= 640, 32'h0000_0001);
  endtask
  task automatic tIrq();
    rd(4'h6, s);
    wr(4'h7, 32'h0000_0000);
    op(32'h0000_0004);
    chk(irq, 32'h0000_0000);
    op(32'h0000_0005);
    rd(4'h5, s);
    chk(s & 32'h0000_00B8, 32'h0000_0080);
    wr(4'h7, 32'h0000_0001);
    @(posedge clk);
    #1 chk(irq, 32'h0000_0001);
    wr(4'hF, 32'h0000_FFFF);
    rd(4'hF, s);
    chk(s, 32'h0000_0000);
  endtask
  task automatic completeRun();
    if (failCount == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence after a 17-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    #1 tReset();
    @(posedge clk);
    rst_n <= 1'b1;
    tErase();
    tSuspend();
    tVpp();
    tSleep();
    tIrq();
    completeRun();
  end
  // Watchdog against a hung operation
  initial begin
    #2000000;
    failCount++;
    completeRun();
  end
endmodule
